// [rtl/dmt_channel.sv]
`timescale 1ns/1ps
module dmt_channel import dmt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // lite register bus
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // activation events and external request
  input wire logic [3:0] timer_match_a_event,
  input wire logic serial_tx_empty_event,
  input wire logic serial_rx_full_event,
  input wire logic external_request_n,
  output logic [5:0] event_flag_clear,
  output logic [5:0] event_to_cpu,
  output logic end_irq,
  // system bus master
  output dmt_mem_cmd_t mem_cmd,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic bus_yield_req,
  output logic bus_hold
);
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dmt_state_t;

  // registers
  dmt_ctrl_t ctrl_r;
  logic [23:0] sma_r;   // short memory address, full 24 bits
  logic [7:0] ioa_r;    // io low address
  logic [7:0] rcnt_r;   // repeat counter
  logic [7:0] rinit_r;  // repeat initial count
  logic [23:0] fsa_r;   // full source address
  logic [23:0] fda_r;   // full destination address
  logic [15:0] ntc_r;   // normal transfer counter
  logic [7:0] bsc_r;    // block size counter
  logic [7:0] bsi_r;    // block size initial
  logic [15:0] bcnt_r;  // block count
  logic end_flag_r;     // sticky end of transfer
  // engine state
  dmt_state_t st_r;
  logic [15:0] data_r;     // read data held for the write
  logic in_block_r;        // a block is under way
  logic [23:0] blk_base_r; // block area start address
  logic req_prev_r;        // external request last cycle
  logic edge_pend_r;       // falling edge waiting for service
  logic [5:0] evt_pend_r;  // internal event waiting for service
  // lite bus state
  logic aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // event vector in source-code order
  logic [5:0] evt;
  assign evt = {serial_rx_full_event, serial_tx_empty_event, timer_match_a_event};

  // write and read path handshakes
  logic aw_hs, w_hs, wr_do, wr_ok, ar_hs;
  assign aw_hs = s_awvalid & s_awready;
  assign w_hs = s_wvalid & s_wready;
  assign wr_do = aw_have_r & w_have_r & ~s_bvalid;
  assign ar_hs = s_arvalid & s_arready;

  // mapped offsets: word aligned and within the table
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= DMT_OFS_STAT);
  endfunction
  assign wr_ok = mapped(aw_addr_r);

  // byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (old & ~m) | (d & m);
  endfunction

  // one address step of one or two bytes
  function automatic logic [23:0] adr_step(input logic [23:0] a, input logic [1:0] st, input logic sz);
    logic [23:0] d;
    d = sz ? 24'h2 : 24'h1;
    case (st)
      DMT_STEP_INC: adr_step = a + d;
      DMT_STEP_DEC: adr_step = a - d;
      default: adr_step = a;
    endcase
  endfunction

  // source legality per mode and half
  logic src_ok;
  always_comb begin
    case (ctrl_r.mode)
      DMT_MODE_REPEAT: src_ok = ctrl_r.chan_b ? (ctrl_r.src_sel <= DMT_SRC_LOW)
                                              : (ctrl_r.src_sel <= DMT_SRC_RX);
      DMT_MODE_NORMAL: src_ok = (ctrl_r.src_sel >= DMT_SRC_EDGE) && (ctrl_r.src_sel <= DMT_SRC_AUTO);
      DMT_MODE_BLOCK: src_ok = (ctrl_r.src_sel <= DMT_SRC_TMR3) || (ctrl_r.src_sel == DMT_SRC_EDGE);
      default: src_ok = 1'b0;
    endcase
  end

  // selected event as a one-hot mask, zero for non-event sources
  logic [5:0] evt_sel;
  assign evt_sel = (ctrl_r.src_sel <= DMT_SRC_RX) ? 6'(6'h01 << ctrl_r.src_sel[2:0]) : 6'h00;
  logic armed;
  assign armed = ctrl_r.enable & src_ok;

  // trigger for a new transfer from the idle state
  logic trig, fall;
  assign fall = req_prev_r & ~external_request_n;
  always_comb begin
    if (ctrl_r.src_sel == DMT_SRC_AUTO)
      trig = 1'b1;
    else if (ctrl_r.src_sel == DMT_SRC_LOW)
      trig = ~external_request_n;
    else if (ctrl_r.src_sel == DMT_SRC_EDGE)
      trig = edge_pend_r;
    else
      trig = |(evt_pend_r & evt_sel);
  end
  logic start;
  assign start = (st_r == ST_IDLE) && armed && (trig || in_block_r);

  // addresses of the current transfer
  logic rx_dir;
  logic [23:0] io_adr, src_adr, dst_adr;
  assign rx_dir = (ctrl_r.src_sel == DMT_SRC_RX);
  assign io_adr = {DMT_IO_HI, ioa_r};
  always_comb begin
    if (ctrl_r.mode == DMT_MODE_REPEAT) begin
      src_adr = rx_dir ? io_adr : sma_r;
      dst_adr = rx_dir ? sma_r : io_adr;
    end else begin
      src_adr = fsa_r;
      dst_adr = fda_r;
    end
  end

  // bookkeeping at the end of each write
  logic fin;
  assign fin = (st_r == ST_WR) && mem_ack;
  logic [7:0] rcnt_dec, bsc_dec;
  logic [15:0] ntc_dec, bcnt_dec;
  logic rpt_wrap, norm_end, blk_done, blk_end;
  logic [23:0] sma_nxt, fsa_nxt, fda_nxt, rpt_amt;
  logic [9:0] amt10;
  always_comb begin
    rcnt_dec = rcnt_r - 8'h01;
    ntc_dec = ntc_r - 16'h0001;
    bsc_dec = bsc_r - 8'h01;
    bcnt_dec = bcnt_r - 16'h0001;
    rpt_wrap = (rcnt_dec == 8'h00);
    norm_end = (ntc_dec == 16'h0000);
    blk_done = (bsc_dec == 8'h00);
    blk_end = blk_done && (bcnt_dec == 16'h0000);
    amt10 = (rinit_r == 8'h00) ? DMT_RPT_FULL : {2'h0, rinit_r};
    amt10 = ctrl_r.size ? {amt10[8:0], 1'b0} : amt10;
    rpt_amt = {14'h0000, amt10};
    sma_nxt = adr_step(sma_r, ctrl_r.dir ? DMT_STEP_DEC : DMT_STEP_INC, ctrl_r.size);
    if (rpt_wrap)
      sma_nxt = ctrl_r.dir ? sma_nxt + rpt_amt : sma_nxt - rpt_amt;
    fsa_nxt = adr_step(fsa_r, ctrl_r.src_step, ctrl_r.size);
    fda_nxt = adr_step(fda_r, ctrl_r.dst_step, ctrl_r.size);
    if (ctrl_r.mode == DMT_MODE_BLOCK && blk_done) begin
      if (ctrl_r.blk_src)
        fsa_nxt = blk_base_r;
      else
        fda_nxt = blk_base_r;
    end
  end

  // transfer ends that drop the enable bit; repeat mode never ends
  logic xfer_end;
  assign xfer_end = fin && ((ctrl_r.mode == DMT_MODE_NORMAL && norm_end) ||
                            (ctrl_r.mode == DMT_MODE_BLOCK && blk_end));

  // keep the bus without a release cycle: rest of a block, or an auto burst
  logic keep;
  assign keep = ctrl_r.enable && !bus_yield_req &&
                ((ctrl_r.mode == DMT_MODE_BLOCK && !blk_done) ||
                 (ctrl_r.mode == DMT_MODE_NORMAL && ctrl_r.burst &&
                  ctrl_r.src_sel == DMT_SRC_AUTO && !norm_end));

  // transfer engine: read source, then write destination
  dmt_state_t st_nxt;
  always_comb begin
    case (st_r)
      ST_IDLE: st_nxt = start ? ST_RD : ST_IDLE;
      ST_RD: st_nxt = mem_ack ? ST_WR : ST_RD;
      ST_WR: st_nxt = mem_ack ? (keep ? ST_RD : ST_IDLE) : ST_WR;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // state and bus ownership; idle always gives one cycle back to the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      bus_hold <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bus_hold <= (st_nxt != ST_IDLE);
    end
  end

  // command toward the system bus, address and data held until ack
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_cmd <= '0;
      data_r <= 16'h0000;
    end else begin
      if (st_r == ST_RD && mem_ack)
        data_r <= mem_rdata;
      case (st_nxt)
        ST_RD: mem_cmd <= '{req: 1'b1, we: 1'b0, size: ctrl_r.size, addr: fin ? (
          ctrl_r.mode == DMT_MODE_REPEAT ? (rx_dir ? io_adr : sma_nxt) : fsa_nxt) : src_adr, wdata: 16'h0000};
        ST_WR: mem_cmd <= '{req: 1'b1, we: 1'b1, size: ctrl_r.size, addr: dst_adr,
                           wdata: (st_r == ST_RD) ? mem_rdata : data_r};
        default: mem_cmd <= '0;
      endcase
    end
  end

  // block tracking: base captured when a block starts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_block_r <= 1'b0;
      blk_base_r <= 24'h000000;
    end else if (ctrl_r.mode != DMT_MODE_BLOCK) begin
      in_block_r <= 1'b0;
    end else if (start && !in_block_r) begin
      in_block_r <= 1'b1;
      blk_base_r <= ctrl_r.blk_src ? fsa_r : fda_r;
    end else if (fin && blk_done) begin
      in_block_r <= 1'b0; // wait for next request
    end
  end

  // request capture: set wins over the clear at start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_prev_r <= 1'b1;
      edge_pend_r <= 1'b0;
      evt_pend_r <= 6'h00;
      event_flag_clear <= 6'h00;
      event_to_cpu <= 6'h00;
    end else begin
      req_prev_r <= external_request_n;
      if (armed && ctrl_r.src_sel == DMT_SRC_EDGE && fall)
        edge_pend_r <= 1'b1;
      else if (start && !in_block_r)
        edge_pend_r <= 1'b0;
      // in block mode a request during a block stays pending, unless a restart after a bus yield clears it
      for (int i = 0; i < 6; i++) begin
        if (armed && evt_sel[i] && evt[i])
          evt_pend_r[i] <= 1'b1;
        else if (start)
          evt_pend_r[i] <= 1'b0;
      end
      event_flag_clear <= armed ? (evt & evt_sel) : 6'h00;
      event_to_cpu <= ctrl_r.enable ? (evt & ~evt_sel) : evt;
    end
  end

  // register file: engine updates, software writes take precedence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= DMT_CTRL_RST;
      sma_r <= 24'h000000;
      ioa_r <= 8'h00;
      rcnt_r <= 8'h00;
      rinit_r <= 8'h00;
      fsa_r <= 24'h000000;
      fda_r <= 24'h000000;
      ntc_r <= 16'h0000;
      bsc_r <= 8'h00;
      bsi_r <= 8'h00;
      bcnt_r <= 16'h0000;
    end else begin
      if (fin) begin
        case (ctrl_r.mode)
          DMT_MODE_REPEAT: begin
            sma_r <= sma_nxt;
            rcnt_r <= rpt_wrap ? rinit_r : rcnt_dec;
          end
          DMT_MODE_NORMAL: begin
            fsa_r <= fsa_nxt;
            fda_r <= fda_nxt;
            ntc_r <= ntc_dec;
          end
          default: begin
            fsa_r <= fsa_nxt;
            fda_r <= fda_nxt;
            bsc_r <= blk_done ? bsi_r : bsc_dec;
            if (blk_done)
              bcnt_r <= bcnt_dec;
          end
        endcase
        if (xfer_end)
          ctrl_r.enable <= 1'b0;
      end
      // clearing and setting enable touches no count or address, so a
      // stopped channel resumes where it left off
      if (wr_do && wr_ok) begin
        case (aw_addr_r)
          DMT_OFS_CTRL: ctrl_r <= dmt_ctrl_t'(DMT_CTRL_W'(merge(32'(ctrl_r), w_data_r, w_strb_r)));
          DMT_OFS_SMA: sma_r <= 24'(merge(32'(sma_r), w_data_r, w_strb_r));
          DMT_OFS_IOA: ioa_r <= 8'(merge(32'(ioa_r), w_data_r, w_strb_r));
          DMT_OFS_RCNT: rcnt_r <= 8'(merge(32'(rcnt_r), w_data_r, w_strb_r));
          DMT_OFS_RINIT: rinit_r <= 8'(merge(32'(rinit_r), w_data_r, w_strb_r));
          DMT_OFS_FSA: fsa_r <= 24'(merge(32'(fsa_r), w_data_r, w_strb_r));
          DMT_OFS_FDA: fda_r <= 24'(merge(32'(fda_r), w_data_r, w_strb_r));
          DMT_OFS_NTC: ntc_r <= 16'(merge(32'(ntc_r), w_data_r, w_strb_r));
          DMT_OFS_BSC: bsc_r <= 8'(merge(32'(bsc_r), w_data_r, w_strb_r));
          DMT_OFS_BSI: bsi_r <= 8'(merge(32'(bsi_r), w_data_r, w_strb_r));
          DMT_OFS_BCNT: bcnt_r <= 16'(merge(32'(bcnt_r), w_data_r, w_strb_r));
          default: ;
        endcase
      end
    end
  end

  // end flag and interrupt line; a new end wins over a write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      end_flag_r <= 1'b0;
      end_irq <= 1'b0;
    end else begin
      if (xfer_end)
        end_flag_r <= 1'b1;
      else if (wr_do && aw_addr_r == DMT_OFS_STAT && w_strb_r[0] && w_data_r[0])
        end_flag_r <= 1'b0;
      end_irq <= (end_flag_r | xfer_end) & ctrl_r.end_ie;
    end
  end

  // lite write channel: address and data taken in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= DMT_RESP_OK;
    end else begin
      if (aw_hs)
        aw_addr_r <= s_awaddr;
      if (w_hs) begin
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      aw_have_r <= (aw_have_r | aw_hs) & ~wr_do;
      w_have_r <= (w_have_r | w_hs) & ~wr_do;
      s_awready <= ~((aw_have_r | aw_hs) & ~wr_do);
      s_wready <= ~((w_have_r | w_hs) & ~wr_do);
      if (wr_do) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? DMT_RESP_OK : DMT_RESP_ERR;
      end else if (s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // lite read channel: one outstanding read
  logic [31:0] rd_mux;
  always_comb begin
    case (s_araddr)
      DMT_OFS_CTRL: rd_mux = 32'(ctrl_r);
      DMT_OFS_SMA: rd_mux = 32'(sma_r);
      DMT_OFS_IOA: rd_mux = 32'(ioa_r);
      DMT_OFS_RCNT: rd_mux = 32'(rcnt_r);
      DMT_OFS_RINIT: rd_mux = 32'(rinit_r);
      DMT_OFS_FSA: rd_mux = 32'(fsa_r);
      DMT_OFS_FDA: rd_mux = 32'(fda_r);
      DMT_OFS_NTC: rd_mux = 32'(ntc_r);
      DMT_OFS_BSC: rd_mux = 32'(bsc_r);
      DMT_OFS_BSI: rd_mux = 32'(bsi_r);
      DMT_OFS_BCNT: rd_mux = 32'(bcnt_r);
      DMT_OFS_STAT: rd_mux = {28'h0000000, in_block_r, st_r != ST_IDLE, ctrl_r.enable, end_flag_r};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= DMT_RESP_OK;
    end else begin
      if (ar_hs) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= mapped(s_araddr) ? DMT_RESP_OK : DMT_RESP_ERR;
      end else if (s_rready)
        s_rvalid <= 1'b0;
      s_arready <= ~(ar_hs | (s_rvalid & ~s_rready));
    end
  end

  // checks
  property p_rpt_reload;
    @(posedge clk) disable iff (sys_rst)
      fin && ctrl_r.mode == DMT_MODE_REPEAT && rcnt_r == 8'h01 && !wr_do |=> rcnt_r == $past(rinit_r);
  endproperty
  a_rpt_reload: assert property (p_rpt_reload) else $error("repeat count not reloaded");
  property p_rpt_restore;
    @(posedge clk) disable iff (sys_rst)
      fin && ctrl_r.mode == DMT_MODE_REPEAT && rcnt_r == 8'h01 && !ctrl_r.dir && !ctrl_r.size
      && rinit_r != 8'h00 && !wr_do |=> sma_r == $past(sma_r) + 24'h1 - {16'h0000, $past(rinit_r)};
  endproperty
  a_rpt_restore: assert property (p_rpt_restore) else $error("repeat address not restored");
  property p_rpt_runs;
    @(posedge clk) disable iff (sys_rst)
      fin && ctrl_r.mode == DMT_MODE_REPEAT && !wr_do |=> ctrl_r.enable == $past(ctrl_r.enable) && !$rose(end_flag_r);
  endproperty
  a_rpt_runs: assert property (p_rpt_runs) else $error("repeat channel stopped");
  property p_io_page;
    @(posedge clk) disable iff (sys_rst)
      mem_cmd.req && mem_cmd.we && ctrl_r.mode == DMT_MODE_REPEAT && !rx_dir |-> mem_cmd.addr[23:8] == DMT_IO_HI;
  endproperty
  a_io_page: assert property (p_io_page) else $error("io address upper bits wrong");
  property p_norm_end;
    @(posedge clk) disable iff (sys_rst)
      fin && ctrl_r.mode == DMT_MODE_NORMAL && ntc_r == 16'h0001 && !wr_do
      |=> !ctrl_r.enable && end_flag_r ##1 (end_irq == ctrl_r.end_ie);
  endproperty
  a_norm_end: assert property (p_norm_end) else $error("normal end not taken");
  property p_steal;
    @(posedge clk) disable iff (sys_rst)
      fin && ctrl_r.mode == DMT_MODE_NORMAL && !ctrl_r.burst |=> !bus_hold && st_r == ST_IDLE;
  endproperty
  a_steal: assert property (p_steal) else $error("bus not released");
  property p_blk_end;
    @(posedge clk) disable iff (sys_rst)
      fin && ctrl_r.mode == DMT_MODE_BLOCK && bsc_r == 8'h01 && bcnt_r == 16'h0001 && !wr_do
      |=> !ctrl_r.enable ##1 st_r == ST_IDLE [*2];
  endproperty
  a_blk_end: assert property (p_blk_end) else $error("block end not taken");
  property p_rd_wr;
    @(posedge clk) disable iff (sys_rst)
      mem_cmd.req && !mem_cmd.we && mem_ack |=> mem_cmd.req && mem_cmd.we && mem_cmd.wdata == $past(mem_rdata);
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("write does not follow read");
  property p_edge;
    @(posedge clk) disable iff (sys_rst)
      armed && ctrl_r.src_sel == DMT_SRC_EDGE && fall && st_r != ST_IDLE |=> edge_pend_r;
  endproperty
  a_edge: assert property (p_edge) else $error("falling edge lost");
  c_rpt_wrap: cover property (@(posedge clk) fin && ctrl_r.mode == DMT_MODE_REPEAT && rpt_wrap);
  c_norm_end: cover property (@(posedge clk) xfer_end && ctrl_r.mode == DMT_MODE_NORMAL);
  c_blk_next: cover property (@(posedge clk) fin && ctrl_r.mode == DMT_MODE_BLOCK && blk_done && !blk_end);
endmodule

// [rtl/dmt_pkg.sv]
// Behaviour
// - repeat counter decrements, reloads from initial at zero
// - repeat reload restores memory address by count
// - repeat runs until disabled, no end interrupt
// - re-enabled repeat channel resumes retained state
// - io address is ones above low byte
// - short memory address holds full 24 bits
// - repeat count zero gives 256 transfers
// - repeat accepts timer and serial requests, external only on the b half
// - normal mode joins halves, 24-bit addresses
// - normal counter ends at zero, optional interrupt
// - normal count zero gives 65536 transfers
// - auto request runs from setup alone
// - cycle steal releases bus every transfer
// - normal burst holds bus for auto requests only, unless higher master asks
// - block burst, size reload, area restore, count down
// - area select zero restores destination, else source
// - block end waits or finishes with interrupt
// - block accepts timer events and external edge
// - activation sources limited per mode and half
// - one transfer per falling external request edge, one whole block in block mode
// - activating event flag cleared, not forwarded
package dmt_pkg;
  // register byte offsets on the lite bus
  localparam logic [7:0] DMT_OFS_CTRL = 8'h00;
  localparam logic [7:0] DMT_OFS_SMA = 8'h04;
  localparam logic [7:0] DMT_OFS_IOA = 8'h08;
  localparam logic [7:0] DMT_OFS_RCNT = 8'h0c;
  localparam logic [7:0] DMT_OFS_RINIT = 8'h10;
  localparam logic [7:0] DMT_OFS_FSA = 8'h14;
  localparam logic [7:0] DMT_OFS_FDA = 8'h18;
  localparam logic [7:0] DMT_OFS_NTC = 8'h1c;
  localparam logic [7:0] DMT_OFS_BSC = 8'h20;
  localparam logic [7:0] DMT_OFS_BSI = 8'h24;
  localparam logic [7:0] DMT_OFS_BCNT = 8'h28;
  localparam logic [7:0] DMT_OFS_STAT = 8'h2c;
  // control register, low 17 bits, packed from bit 0 upward
  typedef struct packed {
    logic [3:0] src_sel;  // bits 16:13 activation source
    logic blk_src;        // bit 12 block area is source when set
    logic burst;          // bit 11 burst when set, else cycle steal, normal mode only
    logic [1:0] mode;     // bits 10:9 transfer mode
    logic [1:0] dst_step; // bits 8:7 destination step, full modes
    logic [1:0] src_step; // bits 6:5 source step, full modes
    logic chan_b;         // bit 4 short channel is the b half
    logic dir;            // bit 3 address direction bit, short mode
    logic size;           // bit 2 transfer size bit, word when set
    logic end_ie;         // bit 1 end interrupt enable
    logic enable;         // bit 0 channel enable bit
  } dmt_ctrl_t;
  localparam int DMT_CTRL_W = 17;
  localparam dmt_ctrl_t DMT_CTRL_RST = '0;
  // mode encodings
  localparam logic [1:0] DMT_MODE_REPEAT = 2'h0;
  localparam logic [1:0] DMT_MODE_NORMAL = 2'h1;
  localparam logic [1:0] DMT_MODE_BLOCK = 2'h2;
  // address step encodings
  localparam logic [1:0] DMT_STEP_FIX = 2'h0;
  localparam logic [1:0] DMT_STEP_INC = 2'h1;
  localparam logic [1:0] DMT_STEP_DEC = 2'h2;
  // activation sources: 0..3 timer match a, then serial, external, auto
  localparam logic [3:0] DMT_SRC_TMR3 = 4'h3;
  localparam logic [3:0] DMT_SRC_TX = 4'h4;
  localparam logic [3:0] DMT_SRC_RX = 4'h5;
  localparam logic [3:0] DMT_SRC_EDGE = 4'h6;
  localparam logic [3:0] DMT_SRC_LOW = 4'h7;
  localparam logic [3:0] DMT_SRC_AUTO = 4'h8;
  // fixed io page above the low byte
  localparam logic [15:0] DMT_IO_HI = 16'hffff;
  localparam logic [9:0] DMT_RPT_FULL = 10'h100;
  // lite bus responses
  localparam logic [1:0] DMT_RESP_OK = 2'h0;
  localparam logic [1:0] DMT_RESP_ERR = 2'h2;
  // command toward the system bus
  typedef struct packed {
    logic req;
    logic we;
    logic size;
    logic [23:0] addr;
    logic [15:0] wdata;
  } dmt_mem_cmd_t;
endpackage

// [tb/dmt_mem_model.sv]
`timescale 1ns/1ps
module dmt_mem_model import dmt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // system bus side
  input wire dmt_mem_cmd_t mem_cmd,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // observation for the bench
  output logic [23:0] last_waddr,
  output logic [7:0] n_wr
);
  logic [1:0] wait_r; // slow answer, three cycles per access
  logic hit;          // this cycle completes the access
  assign hit = mem_cmd.req && !mem_ack && wait_r == 2'h2;
  // acknowledge one access, record write side
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 2'h0;
      mem_ack <= 1'b0;
      last_waddr <= 24'h0;
      n_wr <= 8'h0;
    end else begin
      wait_r <= (mem_cmd.req && !hit && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      mem_ack <= hit;
      if (hit && mem_cmd.we) begin
        last_waddr <= mem_cmd.addr;
        n_wr <= n_wr + 8'h1;
      end
    end
  end
  // data only valid with ack, toggles otherwise so stale reads show
  always_ff @(posedge clk) mem_rdata <= hit ? mem_cmd.addr[15:0] : ~mem_rdata;
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module tb import dmt_pkg::*;;
  logic clk = 0, sys_rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rd, rdv;
  logic awr, wr, bv, arr, rv, irq, hold, ack, ext_n = 1, yld = 0, tx = 0, rx = 0;
  logic [1:0] br, rr;
  logic [3:0] tmr = 0;
  logic [5:0] fclr, tocpu;
  logic [15:0] mrd;
  logic [23:0] lwa;
  logic [7:0] nwr, n0;
  dmt_mem_cmd_t cmd;
  int miscompares = 0, n_tests = 0;
  always #20 clk = ~clk;
  dmt_channel i_dmt_channel (.clk(clk), .sys_rst(sys_rst), .s_awaddr(aw), .s_awvalid(awv), .s_awready(awr),
    .s_wdata(wd), .s_wstrb(4'hf), .s_wvalid(wv), .s_wready(wr), .s_bresp(br), .s_bvalid(bv), .s_bready(bre),
    .s_araddr(ar), .s_arvalid(arv), .s_arready(arr), .s_rdata(rd), .s_rresp(rr), .s_rvalid(rv), .s_rready(rre),
    .timer_match_a_event(tmr), .serial_tx_empty_event(tx), .serial_rx_full_event(rx), .external_request_n(ext_n),
    .event_flag_clear(fclr), .event_to_cpu(tocpu), .end_irq(irq), .mem_cmd(cmd), .mem_rdata(mrd),
    .mem_ack(ack), .bus_yield_req(yld), .bus_hold(hold));
  dmt_mem_model i_dmt_mem_model (.clk(clk), .sys_rst(sys_rst), .mem_cmd(cmd), .mem_rdata(mrd), .mem_ack(ack),
    .last_waddr(lwa), .n_wr(nwr));
  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // lite write: hold each channel until its own handshake
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      complete_run();
    end
    `CHK(br, er)
  endtask
  // lite read, data taken at the edge where rvalid is seen
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    int n = 0;
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      complete_run();
    end
    rdv = rd;
    `CHK(rr, er)
  endtask
  // one timer event pulse, then wait for its write to land
  task automatic kick;
    int n = 0;
    n0 = nwr;
    tmr <= 4'h1;
    @(posedge clk);
    tmr <= 4'h0;
    @(posedge clk);
    `CHK(fclr[0], 1'b1)
    `CHK(tocpu[0], 1'b0)
    while (nwr === n0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) begin
      miscompares++;
      complete_run();
    end
    `CHK(hold, 1'b1)
    repeat (3) @(posedge clk);
    `CHK(hold, 1'b0)
  endtask
  // one falling edge on the external request, then wait for the writes
  task automatic pulse(input logic [7:0] want);
    int n = 0;
    ext_n <= 1'b0;
    @(posedge clk);
    ext_n <= 1'b1;
    while (nwr !== want && n < 80) begin
      @(posedge clk);
      n++;
    end
    if (n >= 80) begin
      miscompares++;
      complete_run();
    end
    repeat (12) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(DMT_OFS_CTRL, DMT_RESP_OK);
    `CHK(rdv, 32'h0)
    axr(8'h30, DMT_RESP_ERR);
    axw(8'h30, 32'h1, DMT_RESP_ERR);
    axw(DMT_OFS_SMA, 32'h001000, DMT_RESP_OK);
    axw(DMT_OFS_IOA, 32'h42, DMT_RESP_OK);
    axw(DMT_OFS_RCNT, 32'h2, DMT_RESP_OK);
    axw(DMT_OFS_RINIT, 32'h2, DMT_RESP_OK);
    axw(DMT_OFS_CTRL, 32'h3, DMT_RESP_OK);
    kick();
    `CHK(lwa, 24'hffff42)
    `CHK(tocpu[0], 1'b0)
    axr(DMT_OFS_RCNT, DMT_RESP_OK);
    `CHK(rdv[7:0], 8'h1)
    axw(DMT_OFS_CTRL, 32'h0, DMT_RESP_OK);
    axw(DMT_OFS_CTRL, 32'h3, DMT_RESP_OK);
    axr(DMT_OFS_RCNT, DMT_RESP_OK);
    `CHK(rdv[7:0], 8'h1)
    kick();
    axr(DMT_OFS_RCNT, DMT_RESP_OK);
    `CHK(rdv[7:0], 8'h2)
    axr(DMT_OFS_SMA, DMT_RESP_OK);
    `CHK(rdv[23:0], 24'h001000)
    `CHK(irq, 1'b0)
    axw(DMT_OFS_FSA, 32'h000200, DMT_RESP_OK);
    axw(DMT_OFS_FDA, 32'h000300, DMT_RESP_OK);
    axw(DMT_OFS_NTC, 32'h3, DMT_RESP_OK);
    n0 = nwr;
    axw(DMT_OFS_CTRL, 32'h102a3, DMT_RESP_OK);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
    `CHK(irq, 1'b1)
    `CHK(nwr - n0, 8'h3)
    `CHK(lwa, 24'h000302)
    axr(DMT_OFS_STAT, DMT_RESP_OK);
    `CHK(rdv[1:0], 2'h1)
    axw(DMT_OFS_STAT, 32'h1, DMT_RESP_OK);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    axw(DMT_OFS_FSA, 32'h000400, DMT_RESP_OK);
    axw(DMT_OFS_FDA, 32'h000500, DMT_RESP_OK);
    axw(DMT_OFS_BSC, 32'h2, DMT_RESP_OK);
    axw(DMT_OFS_BSI, 32'h2, DMT_RESP_OK);
    axw(DMT_OFS_BCNT, 32'h2, DMT_RESP_OK);
    n0 = nwr;
    axw(DMT_OFS_CTRL, 32'hc4a3, DMT_RESP_OK);
    pulse(n0 + 8'h2);
    `CHK(nwr - n0, 8'h2)
    axr(DMT_OFS_STAT, DMT_RESP_OK);
    `CHK(rdv[3:1], 3'h1)
    axr(DMT_OFS_FDA, DMT_RESP_OK);
    `CHK(rdv[23:0], 24'h000500)
    axr(DMT_OFS_BCNT, DMT_RESP_OK);
    `CHK(rdv[15:0], 16'h0001)
    axr(DMT_OFS_BSC, DMT_RESP_OK);
    `CHK(rdv[7:0], 8'h2)
    pulse(n0 + 8'h4);
    `CHK(lwa, 24'h000501)
    `CHK(irq, 1'b1)
    axr(DMT_OFS_FSA, DMT_RESP_OK);
    `CHK(rdv[23:0], 24'h000404)
    complete_run();
  end
endmodule
